// ### hdl/cct_core.sv
// Summary of operation
// R1: spacing counted in actual clock edges
// R2: ns delays become rounded-up cycle counts
// R3: reads and ODT need locked loop
// R4: no upper bound on clock period
// R5: write recovery ns rounded up to cycles
// R6: auto-precharge uses mode register recovery cycles
// R7: eight-beat or flying chop: latency plus four
// R8: fixed chop: internal write at latency plus two
// R9: finish row operations before power-down state
// R10: refresh to clock-enable low minimum
// R11: readout burst end to mode set gap
// R12: short calibration fixes step within 64
// R13: one cycle activate/precharge before power-down
// R14: per-constraint counters flag dependent events that come too early
module cct_core
  import cct_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cct_cmd_type cmd_i,
  input wire logic cke_i,
  input wire logic dll_locked_i,
  output logic write_start_o,
  output logic powered_down_o,
  output logic zq_busy_o,
  output logic [5:0] imp_code_o
);

  // ============================================================
  // register file
  logic [7:0] mode0_q, mode0_d;
  logic [3:0] wrlat_q, wrlat_d;
  logic [7:0] twr_q, twr_d;
  logic [3:0] viol_q, viol_d;
  logic [5:0] tgt_q, tgt_d;
  logic [5:0] imp_q, imp_d;
  cct_pd_type pd_q, pd_d;
  logic [31:0] rdata_q, rdata_d;
  logic err_q, err_d;
  logic [3:0] viol_set;
  logic setup, access_wr, mapped;
  cct_burst_type burst;

  assign setup = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign mapped = (paddr == `CCT_OFS_MODE0) || (paddr == `CCT_OFS_TIMING) ||
                  (paddr == `CCT_OFS_STATUS) || (paddr == `CCT_OFS_IMPED);
  assign burst = cct_burst_type'(mode0_q[`CCT_BURST_MSB:`CCT_BURST_LSB]);

  // zero-wait slave; read data captured in the setup cycle
  always_comb begin
    mode0_d = mode0_q;
    wrlat_d = wrlat_q;
    twr_d = twr_q;
    tgt_d = tgt_q;
    rdata_d = rdata_q;
    err_d = err_q;
    viol_d = viol_q;
    if (setup) begin
      err_d = !mapped;
      unique case (paddr)
        `CCT_OFS_MODE0: rdata_d = {24'h000000, mode0_q};
        `CCT_OFS_TIMING: rdata_d = {16'h0000, twr_q, 4'h0, wrlat_q};
        `CCT_OFS_STATUS: rdata_d = {20'h00000, pd_q == PD_PENDING, zq_busy_o, powered_down_o, dll_locked_i,
                                    4'h0, viol_q};
        `CCT_OFS_IMPED: rdata_d = {18'h00000, imp_q, 2'h0, tgt_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (access_wr) begin
      unique case (paddr)
        `CCT_OFS_MODE0: mode0_d = pwdata[7:0];
        `CCT_OFS_TIMING: begin
          wrlat_d = pwdata[`CCT_WRLAT_MSB:`CCT_WRLAT_LSB];
          twr_d = pwdata[`CCT_TWR_MSB:`CCT_TWR_LSB];
        end
        `CCT_OFS_STATUS: viol_d = viol_q & ~pwdata[3:0];
        `CCT_OFS_IMPED: tgt_d = pwdata[`CCT_TGT_MSB:`CCT_TGT_LSB];
        default: ;
      endcase
    end
    // a violation in the clearing cycle is kept
    viol_d = viol_d | viol_set;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode0_q <= `CCT_MODE0_RST;
      wrlat_q <= `CCT_WRLAT_RST;
      twr_q <= `CCT_TWR_RST;
      tgt_q <= `CCT_IMP_RST;
      viol_q <= 4'h0;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else begin
      mode0_q <= mode0_d;
      wrlat_q <= wrlat_d;
      twr_q <= twr_d;
      tgt_q <= tgt_d;
      viol_q <= viol_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = psel && penable && err_q;

  // ============================================================
  // constraint counters
  // every counter only sees edges, so a stretched clock never
  // shortens a spacing and needs no upper limit R4
  logic is_mrs, is_wr, is_wra, is_row, is_ref, is_rd, is_zq;
  logic mrd_ok, pden_ok, busy_done, wlat_done, zq_done, rdout_ok;
  logic [7:0] wr_off, pden_val, busy_val;
  logic cke_q, cke_d, cke_fall;

  assign is_mrs = (cmd_i == CMD_MRS);
  assign is_wr = (cmd_i == CMD_WR);
  assign is_wra = (cmd_i == CMD_WRA);
  assign is_row = (cmd_i == CMD_ACT) || (cmd_i == CMD_PRE);
  assign is_ref = (cmd_i == CMD_REF);
  assign is_rd = (cmd_i == CMD_RD) || (cmd_i == CMD_RDA);
  assign is_zq = (cmd_i == CMD_CAL_SHORT);
  assign cke_d = cke_i;
  assign cke_fall = cke_q && !cke_i;

  // chop fixed in mode register starts two early
  assign wr_off = (burst == BURST_CHOP_FIXED) ? `CCT_OFF_CHOP : `CCT_OFF_FULL; // R7 R8

  // earliest clock-enable low after the last command
  always_comb begin
    pden_val = `CCT_PDEN_ACT; // R13
    if (is_ref) begin
      pden_val = `CCT_PDEN_REF; // R10
    end else if (is_wr) begin
      pden_val = 8'({4'h0, wrlat_q} + wr_off + cct_ns_to_cyc(twr_q)); // R5 R2
    end else if (is_wra) begin
      pden_val = 8'({4'h0, wrlat_q} + wr_off + {3'h0, mode0_q[`CCT_WR_MSB:`CCT_WR_LSB]} + 8'h01); // R6
    end
  end

  // row operations and refresh keep the array busy
  assign busy_val = is_ref ? cct_ns_to_cyc(`CCT_TRFC_NS) : cct_ns_to_cyc(`CCT_TROW_NS); // R2

  cct_timer u_mrd (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_i(is_mrs),
                   .value_i(`CCT_MODE_SPACING), .expired_o(mrd_ok)); // R1 R14
  cct_timer u_pden (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_i(is_row || is_ref || is_wr || is_wra),
                    .value_i(pden_val), .expired_o(pden_ok)); // R14
  cct_timer u_busy (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_i(is_row || is_ref),
                    .value_i(busy_val), .expired_o(busy_done));
  cct_timer u_wlat (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_i(is_wr || is_wra),
                    .value_i(8'({4'h0, wrlat_q} + wr_off)), .expired_o(wlat_done)); // R7 R8
  cct_timer u_zq (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_i(is_zq),
                  .value_i(`CCT_ZQ_CYCLES), .expired_o(zq_done)); // R12
  cct_timer u_rdout (.clk_i(clk_i), .reset_n_i(reset_n_i), .load_i(is_rd && mode0_q[`CCT_RDOUT_BIT]),
                     .value_i(8'(`CCT_READ_LAT + `CCT_BURST_END + `CCT_RDOUT_GAP)), .expired_o(rdout_ok)); // R11

  // violations seen at the command pins
  always_comb begin
    viol_set = 4'h0;
    viol_set[0] = is_mrs && !mrd_ok; // R1
    viol_set[1] = (is_rd || cmd_i == CMD_ODT) && !dll_locked_i; // R3
    viol_set[2] = cke_fall && !pden_ok; // R13 R10 R5
    viol_set[3] = is_mrs && !rdout_ok; // R11
  end

  // ============================================================
  // internal write start and calibration
  logic wpend_q, wpend_d, wstart_q, wstart_d;
  logic zpend_q, zpend_d;

  // a new write restarts the latency count; one pending write only
  always_comb begin
    wpend_d = wpend_q;
    wstart_d = 1'b0;
    zpend_d = zpend_q;
    imp_d = imp_q;
    if (is_wr || is_wra) begin
      wpend_d = 1'b1;
    end else if (wpend_q && wlat_done) begin
      wpend_d = 1'b0;
      wstart_d = 1'b1; // R7 R8
    end
    if (is_zq) begin
      zpend_d = 1'b1;
    end else if (zpend_q && zq_done) begin
      zpend_d = 1'b0;
      // one step per calibration covers the smallest correction
      if (imp_q < tgt_q) begin
        imp_d = 6'(imp_q + 6'h01); // R12
      end else if (imp_q > tgt_q) begin
        imp_d = 6'(imp_q - 6'h01); // R12
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wpend_q <= 1'b0;
      wstart_q <= 1'b0;
      zpend_q <= 1'b0;
      imp_q <= `CCT_IMP_RST;
    end else begin
      wpend_q <= wpend_d;
      wstart_q <= wstart_d;
      zpend_q <= zpend_d;
      imp_q <= imp_d;
    end
  end

  assign write_start_o = wstart_q;
  assign zq_busy_o = zpend_q;
  assign imp_code_o = imp_q;

  // ============================================================
  // power-down entry

  // clock-enable may drop while the array is busy; hold off the state
  always_comb begin
    pd_d = pd_q;
    unique case (pd_q)
      PD_ACTIVE: if (cke_fall) begin
        pd_d = busy_done ? PD_DOWN : PD_PENDING; // R9
      end
      PD_PENDING: if (cke_i) begin
        pd_d = PD_ACTIVE;
      end else if (busy_done) begin
        pd_d = PD_DOWN; // R9
      end
      PD_DOWN: if (cke_i) begin
        pd_d = PD_ACTIVE;
      end
      default: pd_d = PD_ACTIVE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pd_q <= PD_ACTIVE;
      cke_q <= 1'b1;
    end else begin
      pd_q <= pd_d;
      cke_q <= cke_d;
    end
  end

  assign powered_down_o = (pd_q == PD_DOWN);

  // ============================================================
  // checks
  a_mrs_spacing: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R1
    is_mrs ##1 (cmd_i == CMD_NOP) [*3] ##1 is_mrs |=> !viol_q[0] || $past(viol_q[0]))
    else $error("mode set at four edges flagged");
  a_dll_read: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R3
    (is_rd && !dll_locked_i) |=> viol_q[1])
    else $error("read without locked loop not flagged");
  a_wstart_full: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R7
    (is_wr && wrlat_q == 4'h5 && burst != BURST_CHOP_FIXED) ##1 (!is_wr && !is_wra) [*8]
    |=> ##1 write_start_o)
    else $error("internal write not at latency plus four");
  a_wstart_chop: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R8
    (is_wr && wrlat_q == 4'h5 && burst == BURST_CHOP_FIXED) ##1 (!is_wr && !is_wra) [*6]
    |=> ##1 write_start_o)
    else $error("internal write not at latency plus two");
  a_pd_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R9
    (pd_q == PD_PENDING && !busy_done) |=> pd_q != PD_DOWN)
    else $error("power-down before array idle");
  a_pd_late: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R13
    is_row ##1 cke_fall |=> !viol_q[2] || $past(viol_q[2]))
    else $error("legal clock-enable low after row command flagged");
  a_zq_window: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R12
    is_zq ##1 !is_zq [*8] |-> zq_busy_o)
    else $error("calibration ended too soon");
  a_viol_sticky: assert property (@(posedge clk_i) disable iff (!reset_n_i) // R11
    (is_mrs && !rdout_ok) |=> viol_q[3])
    else $error("readout gap breach lost");

endmodule

// ### common/cct_defs.svh
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH

// ============================================================
// clock
`define CCT_TCK_NS 40

// ============================================================
// register offsets (byte addresses)
`define CCT_OFS_MODE0 8'h00
`define CCT_OFS_TIMING 8'h04
`define CCT_OFS_STATUS 8'h08
`define CCT_OFS_IMPED 8'h0C

// ============================================================
// field positions
`define CCT_WR_LSB 0
`define CCT_WR_MSB 4
`define CCT_BURST_LSB 5
`define CCT_BURST_MSB 6
`define CCT_RDOUT_BIT 7
`define CCT_WRLAT_LSB 0
`define CCT_WRLAT_MSB 3
`define CCT_TWR_LSB 8
`define CCT_TWR_MSB 15
`define CCT_DLL_BIT 8
`define CCT_PD_BIT 9
`define CCT_ZQ_BIT 10
`define CCT_PEND_BIT 11
`define CCT_TGT_LSB 0
`define CCT_TGT_MSB 5
`define CCT_CUR_LSB 8
`define CCT_CUR_MSB 13

// ============================================================
// reset values
`define CCT_MODE0_RST 8'h0A
`define CCT_WRLAT_RST 4'h5
`define CCT_TWR_RST 8'h0F
`define CCT_IMP_RST 6'h20

// ============================================================
// timing counts, in clock_count_unit
`define CCT_MODE_SPACING 8'h04
`define CCT_ZQ_CYCLES 8'h40
`define CCT_PDEN_ACT 8'h01
`define CCT_PDEN_REF 8'h01
`define CCT_RDOUT_GAP 8'h01
`define CCT_READ_LAT 8'h05
`define CCT_BURST_END 8'h04
`define CCT_OFF_FULL 8'h04
`define CCT_OFF_CHOP 8'h02
// row operation and refresh times in ns
`define CCT_TROW_NS 8'h0F
`define CCT_TRFC_NS 8'hA0

`endif

// ### common/cct_pkg.sv
`include "cct_defs.svh"

package cct_pkg;

  // commands as delivered by the command decoder
  typedef enum logic [3:0] {
    CMD_NOP, CMD_MRS, CMD_ACT, CMD_PRE, CMD_REF, CMD_RD, CMD_RDA,
    CMD_WR, CMD_WRA, CMD_CAL_SHORT, CMD_ODT
  } cct_cmd_type;

  // burst setting held in mode_register_zero
  typedef enum logic [1:0] {
    BURST_EIGHT_FIXED, BURST_ON_THE_FLY, BURST_CHOP_FIXED, BURST_SPARE
  } cct_burst_type;

  typedef enum logic [1:0] {
    PD_ACTIVE, PD_PENDING, PD_DOWN
  } cct_pd_type;

  // rounded-up quotient of a time in ns over the clock period
  function automatic logic [7:0] cct_ns_to_cyc(input logic [7:0] ns);
    logic [8:0] sum;
    sum = {1'b0, ns} + 9'(`CCT_TCK_NS - 1);
    return 8'(sum / 9'(`CCT_TCK_NS));
  endfunction

endpackage

// ### hdl/cct_timer.sv
// ============================================================
// down-counter: expired when the given number of edges has passed
module cct_timer (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [7:0] value_i,
  output logic expired_o
);

  logic [7:0] count_q;
  logic [7:0] count_d;

  // load value-1 so that a load at edge m expires at edge m+value
  always_comb begin
    count_d = count_q;
    if (load_i) begin
      count_d = (value_i == 8'h00) ? 8'h00 : 8'(value_i - 8'h01);
    end else if (count_q != 8'h00) begin
      count_d = 8'(count_q - 8'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_d;
    end
  end

  assign expired_o = (count_q == 8'h00);

endmodule

// ### verif/cct_ctrl_model.sv
// ============================================================
// controller side: issues commands, clock-enable and lock level
module cct_ctrl_model
  import cct_pkg::*;
(
  input wire logic clk_i,
  output cct_cmd_type cmd_o,
  output logic cke_o,
  output logic dll_locked_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero; clock-enable high as reset assumes
  initial begin
    cmd_o = CMD_NOP;
    cke_o = 1'b1;
    dll_locked_o = 1'b1;
  end

  // spacing is counted in edges, so a gap is exact whatever its length
  // a NOP request means drop clock-enable instead of a command
  task automatic act(input cct_cmd_type c, input int dl, input bit breach);
    if (!breach && !dll_locked_o && (c == CMD_RD || c == CMD_RDA || c == CMD_ODT)) begin
      c = CMD_REF;
    end
    repeat (dl - 1) @(posedge clk_i);
    if (c == CMD_NOP) begin
      cke_o <= 1'b0;
    end else begin
      cmd_o <= c;
    end
    @(posedge clk_i);
    cmd_o <= CMD_NOP;
  endtask

  // leave power-down
  task automatic cke_up();
    @(posedge clk_i);
    cke_o <= 1'b1;
  endtask

  task automatic set_lock(input logic b);
    @(posedge clk_i);
    dll_locked_o <= b;
  endtask
endmodule

// ### verif/tb_top.sv
`include "cct_defs.svh"

module tb_top
  import cct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic write_start_o;
  logic powered_down_o;
  logic zq_busy_o;
  logic [5:0] imp_code_o;
  cct_cmd_type cmd;
  logic cke;
  logic dll;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  cct_core i_cct_core (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_i(cmd), .cke_i(cke), .dll_locked_i(dll), .write_start_o(write_start_o),
    .powered_down_o(powered_down_o), .zq_busy_o(zq_busy_o), .imp_code_o(imp_code_o));

  cct_ctrl_model i_cct_ctrl_model (.clk_i(clk_i), .cmd_o(cmd), .cke_o(cke), .dll_locked_o(dll));

  // 25 MHz
  always #20 clk_i = ~clk_i;

  // ============================================================
  // checking and closing
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // hang guard; whole run needs about 760 cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  // ============================================================
  // bus access: hold the request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    // pready high ends this wait; only the bench timeout ends it otherwise
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp, what);
    chk({31'h0, e}, 32'h0, "mapped err");
  endtask

  // read one sticky flag, then clear all of them
  task automatic flag_chk(input int bn, input logic ex);
    logic [31:0] s;
    logic e;
    apb(1'b0, `CCT_OFS_STATUS, 32'h00000000, s, e);
    chk({31'h0, s[bn]}, {31'h0, ex}, "flag");
    wr(`CCT_OFS_STATUS, 32'h0000000F);
  endtask

  // first command, then a second one (or clock-enable low) dl edges later
  task automatic pair(input cct_cmd_type c1, input cct_cmd_type c2, input int dl, input int bn,
                      input logic ex);
    i_cct_ctrl_model.act(c1, 2, 1'b0);
    i_cct_ctrl_model.act(c2, dl, 1'b0);
    repeat (30) @(posedge clk_i);
    if (c2 == CMD_NOP) chk({31'h0, powered_down_o}, 32'h1, "power-down");
    i_cct_ctrl_model.cke_up();
    repeat (3) @(posedge clk_i);
    chk({31'h0, powered_down_o}, 32'h0, "wake");
    flag_chk(bn, ex);
  endtask

  // ============================================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic e;
    int n;
    int p;
    int lw;
    int la;
    int lm;
    cct_cmd_type rc [3];
    rc = '{CMD_RD, CMD_RDA, CMD_ODT};
    lw = 5 + 4 + (41 + 39) / 40;
    la = 5 + 4 + 10 + 1;
    lm = 5 + 4 + 1;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(`CCT_OFS_MODE0, 32'h0000000A, "mode0");
    rd_chk(`CCT_OFS_TIMING, 32'h00000F05, "timing");
    rd_chk(`CCT_OFS_IMPED, 32'h00002020, "imped");
    rd_chk(`CCT_OFS_STATUS, 32'h00000100, "status");
    apb(1'b0, 8'h10, 32'h00000000, d, e);
    chk({31'h0, e}, 32'h1, "unmapped err");
    chk(d, 32'h00000000, "unmapped data");
    $display("test registers done");
    // each burst setting except BURST_SPARE: edges from write command to pulse, pulse width
    for (int b = 0; b < 3; b++) begin
      wr(`CCT_OFS_MODE0, {24'h0, 1'b0, 2'(b), 5'd10});
      i_cct_ctrl_model.act(CMD_WR, 2, 1'b0);
      n = -1;
      p = 0;
      for (int k = 0; k < 16; k++) begin
        @(negedge clk_i);
        if (write_start_o === 1'b1) p++;
        if (write_start_o === 1'b1 && n < 0) n = k;
      end
      chk(32'(n), (b == 2) ? 32'd7 : 32'd9, "write start");
      chk(32'(p), 32'd1, "pulse count");
    end
    $display("test write start done");
    wr(`CCT_OFS_MODE0, 32'h0000008A);
    wr(`CCT_OFS_TIMING, 32'h00002905);
    pair(CMD_MRS, CMD_MRS, 3, 0, 1'b1);
    pair(CMD_MRS, CMD_MRS, 4, 0, 1'b0);
    pair(CMD_WR, CMD_NOP, lw - 1, 2, 1'b1);
    pair(CMD_WR, CMD_NOP, lw, 2, 1'b0);
    pair(CMD_WRA, CMD_NOP, la - 1, 2, 1'b1);
    pair(CMD_WRA, CMD_NOP, la, 2, 1'b0);
    pair(CMD_ACT, CMD_NOP, 1, 2, 1'b0);
    pair(CMD_PRE, CMD_NOP, 1, 2, 1'b0);
    pair(CMD_REF, CMD_NOP, 1, 2, 1'b0);
    pair(CMD_RD, CMD_MRS, lm - 1, 3, 1'b1);
    pair(CMD_RD, CMD_MRS, lm, 3, 1'b0);
    $display("test spacing done");
    // reads and termination without a locked loop are flagged
    i_cct_ctrl_model.set_lock(1'b0);
    foreach (rc[i]) begin
      i_cct_ctrl_model.act(rc[i], 2, 1'b1);
      flag_chk(1, 1'b1);
    end
    i_cct_ctrl_model.set_lock(1'b1);
    i_cct_ctrl_model.act(CMD_RD, 2, 1'b0);
    flag_chk(1, 1'b0);
    $display("test lock done");
    // short calibration: busy span and one step toward the target
    wr(`CCT_OFS_IMPED, 32'h00000022);
    i_cct_ctrl_model.act(CMD_CAL_SHORT, 2, 1'b0);
    n = 0;
    repeat (80) begin
      @(negedge clk_i);
      if (zq_busy_o === 1'b1) n++;
    end
    chk(32'(n), 32'd64, "zq busy");
    chk({26'h0, imp_code_o}, 32'h00000021, "imp step");
    $display("test calibration done");
    report_and_stop();
  end
endmodule
